// file: include/smr_regs.svh
`ifndef SMR_REGS_SVH
`define SMR_REGS_SVH
// ----------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------
`define SMR_CLK_MHZ 40
// Release wait after STOP, in microseconds
`define SMR_STOP_WAIT_MIN_US 17
`define SMR_STOP_WAIT_TYP_US 34
`define SMR_STOP_WAIT_MAX_US 67
// Option byte read wait after reset, in microseconds
`define SMR_OPT_WAIT_MIN_US 277
`define SMR_OPT_WAIT_TYP_US 544
`define SMR_OPT_WAIT_MAX_US 1075
// Least external reset pulse, in microseconds
`define SMR_PIN_LOW_MIN_US 2
// Cycle counts from the typical figures
`define SMR_STOP_WAIT_CYC (`SMR_STOP_WAIT_TYP_US * `SMR_CLK_MHZ)
`define SMR_OPT_WAIT_CYC (`SMR_OPT_WAIT_TYP_US * `SMR_CLK_MHZ)
// Reset value of the oscillator settle select field
`define SMR_OSC_SEL_RST 2'h0
// Reset vector byte addresses
`define SMR_VEC_LO_ADDR 16'h0000
`define SMR_VEC_HI_ADDR 16'h0001
`endif

// file: include/smr_pkg.sv
`default_nettype none
// ----------------------------------------
// Types shared by the sequencer
// ----------------------------------------
package smr_pkg;
	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		SMR_RESET = 6'h01,
		SMR_OPT = 6'h02,
		SMR_SETTLE = 6'h04,
		SMR_RUN = 6'h08,
		SMR_STOP = 6'h10,
		SMR_WAKE = 6'h20
	} smr_state_e;
	// What the core does when released from STOP
	typedef enum logic [1:0] {
		SMR_RES_NONE = 2'h0,
		SMR_RES_NEXT = 2'h1,
		SMR_RES_VECTOR = 2'h2
	} smr_resume_e;
	// Reset source group
	typedef struct packed {
		logic pin_low;
		logic wdt_ovf;
		logic power_on_clear;
		logic lvd_low;
	} smr_rst_src_s;
	// Peripheral run enables during any state
	typedef struct packed {
		logic sys_osc_run;
		logic slow_osc_run;
		logic cpu_run;
		logic tmr16_run;
		logic adc_run;
		logic tmr8_run;
	} smr_run_s;
endpackage : smr_pkg
`default_nettype wire

// file: design/smr_wait_cnt.sv
`include "smr_regs.svh"
`default_nettype none
// ----------------------------------------
// Loadable down counter, done pulses when one count remains
// ----------------------------------------
module smr_wait_cnt #(
	parameter int W = 16
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt_r; // Remaining cycles
	logic busy_r;
	// Load wins over counting so a restart is never missed
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
		end else if (load) begin
			cnt_r <= load_val;
			busy_r <= 1'b1;
		end else if (busy_r) begin
			cnt_r <= cnt_r - W'(1);
			busy_r <= (cnt_r != W'(1));
		end
	end
	assign busy = busy_r;
	assign done = busy_r && (cnt_r == W'(1)) && !load;
endmodule : smr_wait_cnt
`default_nettype wire

// file: design/smr_rst_sync.sv
`default_nettype none
// ----------------------------------------
// Reset merge: rst_b asserts async, sources assert at the next edge; sync release
// ----------------------------------------
module smr_rst_sync (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic any_src,
	output logic int_rst
);
	logic meta_r; // First stage, read only by the second
	logic sync_r;
	// Any source holds reset; release crosses two flops
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
		end else begin
			meta_r <= any_src;
			sync_r <= meta_r | any_src;
		end
	end
	assign int_rst = sync_r;
endmodule : smr_rst_sync
`default_nettype wire

// file: design/smr_seq.sv
`include "smr_regs.svh"
`default_nettype none
// Notes on behaviour
// - Stop instruction enters STOP standby
// - Pending unmasked request cancels stop immediately
// - Fixed wait, plus crystal settle, leaving STOP
// - Clock and CPU halt, port latches hold
// - 16-bit timer, ADC, fast 8-bit timer stop
// - Slow-clocked 8-bit timer runs unless stopped
// - Wake interrupt: settle, then vector or next
// - Mask and enable decide hold, next, vector
// - Reset in STOP releases, then reset processing
// - Option byte read wait after reset release
// - Four reset sources: pin, watchdog, supply detectors
// - All resets alike, vector at 0000H/0001H
// - Pins high impedance, dedicated pin low
// - Pin reset holds while low, releases high
// - Watchdog reset releases itself
// - Supply detector resets release above threshold
// - Both oscillators stop during reset
// - Input-only reset pin low re-resets early
// - Watchdog reset also resets the watchdog
module smr_seq #(
	parameter int NIRQ = 8,
	parameter int STOP_WAIT_CYC = `SMR_STOP_WAIT_CYC,
	parameter int OPT_WAIT_CYC = `SMR_OPT_WAIT_CYC,
	parameter int SETTLE_W = 20
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	// Core side
	input wire logic stop_instr,
	input wire logic [NIRQ-1:0] irq_req_flag,
	input wire logic [NIRQ-1:0] irq_mask_flag,
	input wire logic global_irq_enable,
	// Clock configuration
	input wire logic crystal_sel,
	input wire logic [SETTLE_W-1:0] osc_settle_cycles,
	input wire logic slow_osc_stoppable,
	input wire logic slow_osc_sw_stop,
	input wire logic tmr8_on_slow_clk,
	// Reset sources, grouped
	input wire smr_pkg::smr_rst_src_s rst_src,
	input wire logic reset_pin_as_input,
	// Outputs
	output logic cpu_hold,
	output logic resume_next,
	output logic resume_vector,
	output logic [15:0] vec_fetch_addr,
	output logic port_latch_hold,
	output logic pins_hiz,
	output logic low_during_reset_pin,
	output logic low_during_reset_pin_oe,
	output logic wdt_reset,
	output logic in_stop,
	output var smr_pkg::smr_run_s run
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int CW = 32;
	smr_pkg::smr_state_e state_r, state_nxt; // Sequencer state
	smr_pkg::smr_resume_e res_r, res_nxt; // Chosen resume path
	logic wdt_seen_r, wdt_seen_nxt; // Watchdog caused the last reset
	logic early_r, early_nxt; // Window where input-only pin can re-reset
	logic [SETTLE_W-1:0] settle_r, settle_nxt; // Settle countdown
	logic any_src; // Any reset source active
	logic int_rst; // Merged, synchronised reset
	logic wake_req; // Some request pending and unmasked
	logic pin_rereset; // Early low on the input-only pin
	logic load_opt, load_stop; // Timer starts
	logic tmr_load;
	logic [CW-1:0] tmr_val;
	logic tmr_busy, tmr_done;
	logic cpu_hold_r, res_next_r, res_vec_r, hiz_r, p_low_r, wdt_r, stop_r;
	logic [15:0] vec_r;
	smr_pkg::smr_run_s run_r, run_nxt;

	// ----------------------------------------
	// Reset merge
	// ----------------------------------------
	// Pin-as-input only resets inside the early window
	assign pin_rereset = reset_pin_as_input && early_r && rst_src.pin_low;
	// Four sources, each treated alike unless the pin is input-only
	assign any_src = (rst_src.pin_low && !reset_pin_as_input) || rst_src.wdt_ovf ||
		rst_src.power_on_clear || rst_src.lvd_low || pin_rereset;
	smr_rst_sync u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.any_src(any_src),
		.int_rst(int_rst)
	);

	// ----------------------------------------
	// Shared wait counter
	// ----------------------------------------
	// Unmasked pending request, reduction over all sources
	function automatic logic pending(input logic [NIRQ-1:0] rq, input logic [NIRQ-1:0] mk);
		pending = |(rq & ~mk);
	endfunction : pending
	assign wake_req = pending(irq_req_flag, irq_mask_flag);
	assign load_opt = (state_r == smr_pkg::SMR_RESET) && !int_rst;
	assign load_stop = (state_r == smr_pkg::SMR_STOP) && wake_req && !int_rst;
	assign tmr_load = load_opt || load_stop;
	assign tmr_val = load_opt ? CW'(OPT_WAIT_CYC) : CW'(STOP_WAIT_CYC);
	smr_wait_cnt #(.W(CW)) u_wait (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.load(tmr_load),
		.load_val(tmr_val),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		res_nxt = res_r;
		wdt_seen_nxt = wdt_seen_r;
		early_nxt = early_r;
		settle_nxt = settle_r;
		if (int_rst) begin
			// Any reset, including one during STOP, restarts the sequence
			state_nxt = smr_pkg::SMR_RESET;
			res_nxt = smr_pkg::SMR_RES_NONE;
			// Cause is taken fresh at reset entry, so an old watchdog flag never leaks
			wdt_seen_nxt = rst_src.wdt_ovf ||
				(wdt_seen_r && (state_r == smr_pkg::SMR_RESET));
			early_nxt = 1'b1;
		end else begin
			case (state_r)
				smr_pkg::SMR_RESET: begin
					state_nxt = smr_pkg::SMR_OPT;
				end
				smr_pkg::SMR_OPT: begin
					if (tmr_done) begin
						// Option byte read; the early re-reset window closes
						early_nxt = 1'b0;
						settle_nxt = osc_settle_cycles;
						state_nxt = crystal_sel ? smr_pkg::SMR_SETTLE : smr_pkg::SMR_RUN;
					end
				end
				smr_pkg::SMR_SETTLE: begin
					// Crystal settle; a zero setting takes one cycle, like a setting of one
					if (settle_r <= SETTLE_W'(1)) begin
						state_nxt = smr_pkg::SMR_RUN;
					end else begin
						settle_nxt = settle_r - SETTLE_W'(1);
					end
				end
				smr_pkg::SMR_RUN: begin
					res_nxt = smr_pkg::SMR_RES_NONE;
					// Stop refused when an unmasked request waits
					if (stop_instr && !wake_req) begin
						state_nxt = smr_pkg::SMR_STOP;
					end
				end
				smr_pkg::SMR_STOP: begin
					// Masked requests keep STOP
					if (wake_req) begin
						res_nxt = global_irq_enable ? smr_pkg::SMR_RES_VECTOR :
							smr_pkg::SMR_RES_NEXT;
						state_nxt = smr_pkg::SMR_WAKE;
					end
				end
				smr_pkg::SMR_WAKE: begin
					if (tmr_done) begin
						settle_nxt = osc_settle_cycles;
						state_nxt = crystal_sel ? smr_pkg::SMR_SETTLE : smr_pkg::SMR_RUN;
					end
				end
				default: begin
					state_nxt = smr_pkg::SMR_RESET;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Run enables for the clocked blocks
	// ----------------------------------------
	logic in_rst_phase, stopped, slow_ok;
	assign in_rst_phase = (state_nxt == smr_pkg::SMR_RESET);
	assign stopped = (state_nxt == smr_pkg::SMR_STOP) || (state_nxt == smr_pkg::SMR_WAKE);
	// Slow oscillator runs unless software may stop it and did
	assign slow_ok = !(slow_osc_stoppable && slow_osc_sw_stop);
	always_comb begin
		run_nxt.sys_osc_run = !in_rst_phase && !stopped;
		run_nxt.slow_osc_run = !in_rst_phase && slow_ok;
		run_nxt.cpu_run = (state_nxt == smr_pkg::SMR_RUN);
		run_nxt.tmr16_run = !stopped && !in_rst_phase;
		run_nxt.adc_run = !stopped && !in_rst_phase;
		// Slow-clocked timer survives STOP; the fast one does not
		run_nxt.tmr8_run = tmr8_on_slow_clk ? (slow_ok && !in_rst_phase) :
			(!stopped && !in_rst_phase);
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= smr_pkg::SMR_RESET;
			res_r <= smr_pkg::SMR_RES_NONE;
			wdt_seen_r <= 1'b0;
			early_r <= 1'b1;
			settle_r <= '0;
		end else begin
			state_r <= state_nxt;
			res_r <= res_nxt;
			wdt_seen_r <= wdt_seen_nxt;
			early_r <= early_nxt;
			settle_r <= settle_nxt;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	logic hiz_nxt;
	// Pins float through reset, option read and post-reset settle
	assign hiz_nxt = (state_nxt == smr_pkg::SMR_RESET) || (state_nxt == smr_pkg::SMR_OPT) ||
		((state_nxt == smr_pkg::SMR_SETTLE) && early_nxt == 1'b0 &&
		(state_r == smr_pkg::SMR_OPT || hiz_r));
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cpu_hold_r <= 1'b1;
			res_next_r <= 1'b0;
			res_vec_r <= 1'b0;
			vec_r <= `SMR_VEC_LO_ADDR;
			hiz_r <= 1'b1;
			p_low_r <= 1'b1;
			wdt_r <= 1'b0;
			stop_r <= 1'b0;
			run_r <= '0;
		end else begin
			cpu_hold_r <= (state_nxt != smr_pkg::SMR_RUN);
			// One-cycle resume pulses when the CPU restarts after STOP
			res_next_r <= (state_nxt == smr_pkg::SMR_RUN) && (state_r != smr_pkg::SMR_RUN) &&
				(res_r == smr_pkg::SMR_RES_NEXT);
			res_vec_r <= (state_nxt == smr_pkg::SMR_RUN) && (state_r != smr_pkg::SMR_RUN) &&
				(res_r == smr_pkg::SMR_RES_VECTOR);
			// Fetch address points at the reset vector low byte while held
			vec_r <= `SMR_VEC_LO_ADDR;
			hiz_r <= hiz_nxt;
			p_low_r <= hiz_nxt;
			wdt_r <= int_rst && wdt_seen_nxt;
			stop_r <= stopped;
			run_r <= run_nxt;
		end
	end
	assign cpu_hold = cpu_hold_r;
	assign resume_next = res_next_r;
	assign resume_vector = res_vec_r;
	assign vec_fetch_addr = vec_r;
	assign pins_hiz = hiz_r;
	assign port_latch_hold = stop_r;
	// Dedicated pin driven low while the others float
	assign low_during_reset_pin = 1'b0;
	assign low_during_reset_pin_oe = p_low_r;
	assign wdt_reset = wdt_r;
	assign in_stop = stop_r;
	assign run = run_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_stop_entry;
		@(posedge ref_clk) disable iff (!rst_b || int_rst)
		(state_r == smr_pkg::SMR_RUN && stop_instr && !wake_req) |=> (state_r == smr_pkg::SMR_STOP);
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");
	property p_stop_refused;
		@(posedge ref_clk) disable iff (!rst_b || int_rst)
		(state_r == smr_pkg::SMR_RUN && wake_req) |=> (state_r != smr_pkg::SMR_STOP);
	endproperty
	a_stop_refused: assert property (p_stop_refused) else $error("stop taken with request");
	property p_masked_hold;
		@(posedge ref_clk) disable iff (!rst_b || int_rst)
		(state_r == smr_pkg::SMR_STOP && !wake_req) |=> (state_r == smr_pkg::SMR_STOP);
	endproperty
	a_masked_hold: assert property (p_masked_hold) else $error("masked request left stop");
	property p_wake_path;
		@(posedge ref_clk) disable iff (!rst_b || int_rst)
		(state_r == smr_pkg::SMR_STOP && wake_req && global_irq_enable) |=>
		(res_r == smr_pkg::SMR_RES_VECTOR);
	endproperty
	a_wake_path: assert property (p_wake_path) else $error("vector path not chosen");
	property p_stop_halts;
		@(posedge ref_clk) disable iff (!rst_b)
		in_stop |-> (!run.cpu_run && !run.sys_osc_run && !run.adc_run && !run.tmr16_run);
	endproperty
	a_stop_halts: assert property (p_stop_halts) else $error("block runs in stop");
	property p_rst_osc;
		@(posedge ref_clk) disable iff (!rst_b)
		(state_r == smr_pkg::SMR_RESET) |-> (!run.sys_osc_run && !run.slow_osc_run);
	endproperty
	a_rst_osc: assert property (p_rst_osc) else $error("oscillator runs in reset");
	property p_reset_in_stop;
		@(posedge ref_clk) disable iff (!rst_b)
		(state_r == smr_pkg::SMR_STOP && int_rst) |=> (state_r == smr_pkg::SMR_RESET);
	endproperty
	a_reset_in_stop: assert property (p_reset_in_stop) else $error("reset left stop held");
	property p_hiz_pin;
		@(posedge ref_clk) disable iff (!rst_b)
		pins_hiz |-> low_during_reset_pin_oe;
	endproperty
	a_hiz_pin: assert property (p_hiz_pin) else $error("dedicated pin not driven");
	property p_opt_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		(state_r == smr_pkg::SMR_OPT) |-> cpu_hold;
	endproperty
	a_opt_hold: assert property (p_opt_hold) else $error("cpu runs in option read");
	property p_rst_hiz;
		@(posedge ref_clk) disable iff (!rst_b)
		(state_r == smr_pkg::SMR_RESET || state_r == smr_pkg::SMR_OPT) |->
		(pins_hiz && low_during_reset_pin_oe && cpu_hold);
	endproperty
	a_rst_hiz: assert property (p_rst_hiz) else $error("pins driven in reset");
	property p_wait_busy;
		@(posedge ref_clk) disable iff (!rst_b)
		(state_r == smr_pkg::SMR_OPT || state_r == smr_pkg::SMR_WAKE) |-> tmr_busy;
	endproperty
	a_wait_busy: assert property (p_wait_busy) else $error("wait counter idle");
endmodule : smr_seq
`default_nettype wire

// file: test/smr_far_model.sv
`default_nettype none
// ----------------------------------------
// Core, interrupt sources and reset pin
// ----------------------------------------
module smr_far_model #(
	parameter int NIRQ = 8,
	parameter int PIN_LOW_CYC = 80
) (
	input wire logic ref_clk,
	output logic stop_instr,
	output logic [NIRQ-1:0] irq_req_flag,
	output logic [NIRQ-1:0] irq_mask_flag,
	output logic global_irq_enable,
	output var smr_pkg::smr_rst_src_s rst_src
);
	timeunit 1ns;
	timeprecision 1ps;
	// Cycles the reset pin has been held low so far
	int pin_cyc = 0;
	// Idle: no stop, nothing pending, all masked, sources quiet
	initial begin
		stop_instr = 1'b0;
		irq_req_flag = '0;
		irq_mask_flag = '1;
		global_irq_enable = 1'b0;
		rst_src = '0;
	end
	// Count the pin low time so a short glitch is never sent
	always @(posedge ref_clk) begin
		pin_cyc <= rst_src.pin_low ? pin_cyc + 1 : 0;
	end
	// Core runs the stop instruction for one cycle
	task automatic exec_stop();
		@(negedge ref_clk);
		stop_instr = 1'b1;
		@(negedge ref_clk);
		stop_instr = 1'b0;
	endtask : exec_stop
	// Request, mask and enable change together
	task automatic set_irq(input logic [NIRQ-1:0] req, input logic [NIRQ-1:0] msk,
		input logic en);
		@(negedge ref_clk);
		irq_req_flag = req;
		irq_mask_flag = msk;
		global_irq_enable = en;
	endtask : set_irq
	// New source levels; the pin is never released early
	task automatic src_drive(input logic [3:0] m);
		while (rst_src.pin_low && !m[3] && pin_cyc < PIN_LOW_CYC) begin
			@(negedge ref_clk);
		end
		@(negedge ref_clk);
		rst_src = smr_pkg::smr_rst_src_s'(m);
	endtask : src_drive
endmodule : smr_far_model
`default_nettype wire

// file: test/stop_mode_and_reset_control_bench.sv
`default_nettype none
module stop_mode_and_reset_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Shortened waits keep the run brief
	// ----------------------------------------
	localparam int NIRQ = 8;
	localparam int STOP_W = 8;
	localparam int OPT_W = 16;
	localparam int SETTLE = 10;
	logic ref_clk, rst_b, crystal_sel, slow_osc_stoppable, slow_osc_sw_stop;
	logic tmr8_on_slow_clk, reset_pin_as_input, stop_instr, global_irq_enable;
	logic [NIRQ-1:0] irq_req_flag, irq_mask_flag;
	logic [19:0] osc_settle_cycles;
	smr_pkg::smr_rst_src_s rst_src;
	logic cpu_hold, resume_next, resume_vector, port_latch_hold, pins_hiz;
	logic low_during_reset_pin, low_during_reset_pin_oe, wdt_reset, in_stop;
	logic [15:0] vec_fetch_addr;
	smr_pkg::smr_run_s run;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	// Far side: core, interrupts, reset sources
	smr_far_model far (.ref_clk(ref_clk), .stop_instr(stop_instr),
		.irq_req_flag(irq_req_flag), .irq_mask_flag(irq_mask_flag),
		.global_irq_enable(global_irq_enable), .rst_src(rst_src));
	smr_seq #(.STOP_WAIT_CYC(STOP_W), .OPT_WAIT_CYC(OPT_W)) dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .stop_instr(stop_instr),
		.irq_req_flag(irq_req_flag), .irq_mask_flag(irq_mask_flag),
		.global_irq_enable(global_irq_enable), .crystal_sel(crystal_sel),
		.osc_settle_cycles(osc_settle_cycles), .slow_osc_stoppable(slow_osc_stoppable),
		.slow_osc_sw_stop(slow_osc_sw_stop), .tmr8_on_slow_clk(tmr8_on_slow_clk),
		.rst_src(rst_src), .reset_pin_as_input(reset_pin_as_input), .cpu_hold(cpu_hold),
		.resume_next(resume_next), .resume_vector(resume_vector),
		.vec_fetch_addr(vec_fetch_addr), .port_latch_hold(port_latch_hold),
		.pins_hiz(pins_hiz), .low_during_reset_pin(low_during_reset_pin),
		.low_during_reset_pin_oe(low_during_reset_pin_oe), .wdt_reset(wdt_reset),
		.in_stop(in_stop), .run(run));
	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			$display("ERROR at %0t: run did not finish", $time);
			report_and_stop();
		end
	end
	// ----------------------------------------
	// Compare tasks
	// ----------------------------------------
	task automatic chk_bit(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: %s is %b, want %b", $time, what, got, exp);
		end
	endtask : chk_bit
	task automatic chk_run(input smr_pkg::smr_run_s got, input logic [5:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: run enables %b, want %b", $time, got, exp);
		end
	endtask : chk_run
	task automatic chk_span(input int got, input int lo, input string what);
		checked++;
		// A few cycles of slack cover the release synchroniser
		if (got < lo || got > lo + 6) begin
			errors++;
			$display("ERROR at %0t: %s took %0d, want %0d..%0d", $time, what, got, lo, lo + 6);
		end
	endtask : chk_span
	// Cycles until the core is let go, bounded
	task automatic wait_release(output int cnt);
		cnt = 0;
		while (cpu_hold !== 1'b0 && cnt < 2000) begin
			@(negedge ref_clk);
			cnt++;
		end
	endtask : wait_release
	// One stop entry, masked hold, then unmasked wake
	task automatic stop_case(input logic tslow, input logic stp, input logic sws,
		input logic en, input logic xtal, input logic [5:0] exp, input int lo);
		@(negedge ref_clk);
		tmr8_on_slow_clk = tslow;
		slow_osc_stoppable = stp;
		slow_osc_sw_stop = sws;
		crystal_sel = xtal;
		// Settle setting is whatever the expected span holds beyond the fixed wait
		osc_settle_cycles = 20'(lo - STOP_W);
		far.exec_stop();
		chk_bit(in_stop, 1'b1, "in_stop");
		chk_bit(port_latch_hold, 1'b1, "latch hold");
		chk_bit(cpu_hold, 1'b1, "cpu_hold");
		chk_run(run, exp);
		far.set_irq(8'h01, 8'h01, en);
		repeat (STOP_W + 6) @(negedge ref_clk);
		chk_bit(in_stop, 1'b1, "masked in_stop");
		far.set_irq(8'h01, 8'h00, en);
		wait_release(n);
		chk_span(n, lo, "stop wake");
		chk_bit(resume_next, ~en, "resume_next");
		chk_bit(resume_vector, en, "resume_vector");
		@(negedge ref_clk);
		chk_bit(in_stop, 1'b0, "in_stop after wake");
		far.set_irq(8'h00, 8'hFF, 1'b0);
		$display("test stop wake done, errors %0d", errors);
	endtask : stop_case
	// ----------------------------------------
	// Closing report
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		crystal_sel = 1'b0;
		osc_settle_cycles = SETTLE;
		slow_osc_stoppable = 1'b0;
		slow_osc_sw_stop = 1'b0;
		tmr8_on_slow_clk = 1'b1;
		reset_pin_as_input = 1'b0;
		repeat (12) @(negedge ref_clk);
		// Power-up reset: pins floated, dedicated pin driven low
		chk_bit(pins_hiz, 1'b1, "pins_hiz");
		chk_bit(low_during_reset_pin_oe, 1'b1, "low pin oe");
		chk_bit(low_during_reset_pin, 1'b0, "low pin");
		chk_run(run, 6'h00);
		rst_b = 1'b1;
		wait_release(n);
		chk_span(n, OPT_W, "option wait");
		chk_bit(vec_fetch_addr === 16'h0000, 1'b1, "vector address");
		@(negedge ref_clk);
		chk_bit(pins_hiz, 1'b0, "pins_hiz in run");
		$display("test power up done, errors %0d", errors);
		// Four osc and timer combinations, both wake kinds
		stop_case(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 6'h11, STOP_W);
		stop_case(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 6'h00, STOP_W + SETTLE);
		stop_case(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 6'h10, STOP_W);
		stop_case(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 6'h11, STOP_W);
		// Pending unmasked request refuses stop
		far.set_irq(8'h02, 8'h00, 1'b0);
		far.exec_stop();
		chk_bit(in_stop, 1'b0, "refused stop");
		chk_bit(cpu_hold, 1'b0, "refused hold");
		far.set_irq(8'h00, 8'hFF, 1'b0);
		$display("test stop refused done, errors %0d", errors);
		// Each source alone: pin, watchdog, power-on clear, low supply
		for (int i = 0; i < 4; i++) begin
			far.src_drive(4'h8 >> i);
			repeat (2) @(negedge ref_clk);
			// Cause flag must be right from the first reset cycle on
			chk_bit(wdt_reset, i == 1, "wdt_reset early");
			repeat (2) @(negedge ref_clk);
			chk_bit(cpu_hold, 1'b1, "source hold");
			chk_bit(pins_hiz, 1'b1, "source hiz");
			chk_run(run, 6'h00);
			chk_bit(wdt_reset, i == 1, "wdt_reset");
			far.src_drive(4'h0);
			wait_release(n);
			chk_span(n, OPT_W, "source release");
			chk_bit(vec_fetch_addr === 16'h0000, 1'b1, "vector address");
		end
		$display("test reset sources done, errors %0d", errors);
		// Reset in STOP; crystal with a zero settle setting adds one cycle
		crystal_sel = 1'b1;
		far.exec_stop();
		far.src_drive(4'h2);
		repeat (3) @(negedge ref_clk);
		chk_bit(in_stop, 1'b0, "stop released by reset");
		far.src_drive(4'h0);
		wait_release(n);
		chk_span(n, OPT_W + 1, "reset from stop");
		crystal_sel = 1'b0;
		$display("test reset in stop done, errors %0d", errors);
		// Input-only pin: ignored in run, resets in the option window
		reset_pin_as_input = 1'b1;
		far.src_drive(4'h8);
		repeat (4) @(negedge ref_clk);
		chk_bit(cpu_hold, 1'b0, "pin ignored in run");
		far.src_drive(4'h0);
		far.src_drive(4'h4);
		far.src_drive(4'h0);
		repeat (4) @(negedge ref_clk);
		far.src_drive(4'h8);
		far.src_drive(4'h0);
		chk_bit(cpu_hold, 1'b1, "held while pin low");
		wait_release(n);
		chk_span(n, OPT_W, "early pin release");
		$display("test early pin reset done, errors %0d", errors);
		report_and_stop();
	end
endmodule : stop_mode_and_reset_control_bench
`default_nettype wire
